// ==== design/tpc_host.sv ====
// host controller that programs and updates the timer unit pwm channels
// Summary of operation
// - shorten unbuffered width: arm channel interrupt, write value after it fires
// - lengthen unbuffered width: arm wrap interrupt, write value after it fires
// - never program toggle-on-compare output action for a pwm channel
// - buffered updates go only to the inactive value pair
// - init: halt counter first, then reset counter and prescaler
// - init: load period limit, then channel pulse width
// - mode select 0:1 for unbuffered, 1:0 for buffered
// - set toggle_on_wrap unless config zero bit is set; action 1:0 clears or 1:1 sets on compare
// - final init step clears the counter halt bit
// - halt the timer before wait when no timer function is needed
`timescale 1ns/1ps
module tpc_host (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // software apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // apb master to timer unit
   output logic             m_psel,
   output logic             m_penable,
   output logic             m_pwrite,
   output logic [7:0]       m_paddr,
   output logic [31:0]      m_pwdata,
   input  wire logic [31:0] m_prdata,
   input  wire logic        m_pready,
   // timer unit interrupt pin
   input  wire logic        timer_irq
);
   import tpc_pkg::*;

   function automatic logic [7:0] ch_base(input logic [2:0] ch);
      ch_base = TPC_DEV_CH0 + 8'(ch) * TPC_DEV_CH_STR;
   endfunction : ch_base

   function automatic logic [7:0] main_val(input logic halt, input logic rst,
                                           input logic ien, input logic [2:0] ps);
      main_val = 8'h00;
      main_val[TPC_MAIN_HALT]  = halt;
      main_val[TPC_MAIN_RST]   = rst;
      main_val[TPC_MAIN_IRQEN] = ien;
      main_val[2:0]            = ps;
   endfunction : main_val

   // control value: legal mode pair, never toggle-on-compare
   function automatic logic [7:0] cc_val(input logic buf_m, input logic setc,
                                         input logic zero, input logic full,
                                         input logic ien);
      cc_val = 8'h00;
      cc_val[TPC_CC_IRQEN] = ien;
      cc_val[TPC_CC_BUF]   = buf_m;
      cc_val[TPC_CC_UNBUF] = ~buf_m;
      cc_val[TPC_CC_ACTH]  = 1'b1;
      cc_val[TPC_CC_ACTL]  = setc;
      cc_val[TPC_CC_TOV]   = ~zero;
      cc_val[TPC_CC_FULL]  = full;
   endfunction : cc_val

   function automatic tpc_step_t next_step(input tpc_step_t s, input tpc_mode_t m);
      unique case (s)
         SP_HALT:   next_step = (m == M_INIT) ? SP_RST : SP_DONE;
         SP_RST:    next_step = SP_PERH;
         SP_PERH:   next_step = SP_PERL;
         SP_PERL:   next_step = SP_VALH;
         SP_VALH:   next_step = SP_VALL;
         SP_VALL:   next_step = (m == M_INIT) ? SP_CCTL : SP_DONE;
         SP_CCTL:   next_step = SP_GO;
         SP_GO:     next_step = SP_DONE;
         SP_ARM:    next_step = SP_WAIT;
         SP_WAIT:   next_step = SP_RDFLAG;
         SP_RDFLAG: next_step = SP_CLR;
         SP_CLR:    next_step = SP_VALH;
         default:   next_step = SP_DONE;
      endcase
   endfunction : next_step

   // software registers
   logic [15:0]  period_q, width_q, cur_width_q;
   logic [10:0]  config_q;
   logic         err_q, irq_seen_q;
   logic [2:0]   last_odd_q;
   logic [31:0]  last_rd_q, prdata_q;
   logic         irq_m_q, irq_s_q;
   tpc_state_t   state_q;
   tpc_mode_t    mode_q;
   tpc_step_t    step_q;

   wire  [2:0]   cfg_ch    = config_q[TPC_CFG_CH_LSB +: 3];
   wire          cfg_buf   = config_q[TPC_CFG_BUF];
   wire  [2:0]   cfg_ps    = config_q[TPC_CFG_PS_LSB +: 3];
   wire  [1:0]   pair      = cfg_ch[2:1];
   wire          busy      = (state_q != ST_IDLE);
   wire          unb_short = (width_q < cur_width_q);

   // software bus decode
   wire          sw_setup  = psel && !penable;
   wire          sw_wr     = psel && penable && pwrite;
   wire          sw_mapped = (paddr == TPC_SW_CMD) || (paddr == TPC_SW_PERIOD) ||
                             (paddr == TPC_SW_WIDTH) || (paddr == TPC_SW_CONFIG) ||
                             (paddr == TPC_SW_STATUS) || (paddr == TPC_SW_LAST_RD);
   wire          cmd_wr    = sw_wr && (paddr == TPC_SW_CMD);
   wire          cmd_any   = cmd_wr && (pwdata[3:0] != 4'h0);
   wire          cmd_bad   = busy || (pwdata[TPC_CMD_UPDATE] && cfg_buf && cfg_ch[0]) ||
                             (pwdata[TPC_CMD_INIT] && cfg_buf && cfg_ch[0]);
   wire          cmd_go    = cmd_any && !cmd_bad;
   wire [31:0]   status_w  = {25'h0, last_odd_q, 2'b00, err_q, busy};
   wire [31:0]   rd_mux    = (paddr == TPC_SW_PERIOD)  ? {16'h0, period_q} :
                             (paddr == TPC_SW_WIDTH)   ? {16'h0, width_q} :
                             (paddr == TPC_SW_CONFIG)  ? {21'h0, config_q} :
                             (paddr == TPC_SW_STATUS)  ? status_w :
                             (paddr == TPC_SW_LAST_RD) ? last_rd_q : 32'h0;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !sw_mapped;
   assign prdata  = prdata_q;

   // command mode and first step
   wire tpc_mode_t cmd_mode  = pwdata[TPC_CMD_INIT]   ? M_INIT :
                               pwdata[TPC_CMD_UPDATE] ? (cfg_buf ? M_BUF : M_UNBUF) :
                               pwdata[TPC_CMD_HALT]   ? M_HALT : M_GO;
   wire tpc_step_t cmd_first = (cmd_mode == M_INIT || cmd_mode == M_HALT) ? SP_HALT :
                               (cmd_mode == M_BUF) ? SP_VALH :
                               (cmd_mode == M_UNBUF) ? SP_ARM : SP_GO;

   // master bus step handling
   wire            xfer_done = m_psel && m_penable && m_pready;
   wire tpc_step_t nxt_step  = next_step(step_q, mode_q);
   wire tpc_mode_t ld_mode   = (state_q == ST_IDLE) ? cmd_mode : mode_q;
   wire tpc_step_t ld_step   = (state_q == ST_IDLE) ? cmd_first :
                               (state_q == ST_IRQ) ? SP_RDFLAG : nxt_step;
   wire            ld_bus    = (state_q == ST_IDLE) ? cmd_go :
                               (state_q == ST_IRQ) ? irq_s_q :
                               (state_q == ST_ACCESS) ? (xfer_done && nxt_step != SP_DONE &&
                                                         nxt_step != SP_WAIT) : 1'b0;
   // buffered writes target the inactive register pair
   wire            tgt_odd   = (ld_mode == M_BUF) ? ~last_odd_q[pair] : cfg_ch[0];
   wire  [2:0]     val_ch    = {cfg_ch[2:1], tgt_odd};
   wire            arm_ch    = unb_short;
   wire  [7:0]     cc_now    = cc_val(cfg_buf, config_q[TPC_CFG_SETCMP],
                                      config_q[TPC_CFG_ZERO], config_q[TPC_CFG_FULL], 1'b0);
   wire  [7:0]     cc_arm    = cc_val(cfg_buf, config_q[TPC_CFG_SETCMP],
                                      config_q[TPC_CFG_ZERO], config_q[TPC_CFG_FULL], 1'b1);
   wire  [7:0]     ld_addr   =
      (ld_step == SP_PERH) ? TPC_DEV_PER_H :
      (ld_step == SP_PERL) ? TPC_DEV_PER_L :
      (ld_step == SP_VALH) ? ch_base(val_ch) + TPC_DEV_VAL_H :
      (ld_step == SP_VALL) ? ch_base(val_ch) + TPC_DEV_VAL_L :
      (ld_step == SP_CCTL) ? ch_base(cfg_ch) :
      ((ld_step == SP_ARM || ld_step == SP_RDFLAG || ld_step == SP_CLR) && arm_ch) ?
         ch_base(cfg_ch) : TPC_DEV_MAIN;
   wire  [7:0]     ld_byte   =
      (ld_step == SP_HALT) ? main_val(1'b1, 1'b0, 1'b0, cfg_ps) :
      (ld_step == SP_RST)  ? main_val(1'b1, 1'b1, 1'b0, cfg_ps) :
      (ld_step == SP_PERH) ? period_q[15:8] :
      (ld_step == SP_PERL) ? period_q[7:0] :
      (ld_step == SP_VALH) ? width_q[15:8] :
      (ld_step == SP_VALL) ? width_q[7:0] :
      (ld_step == SP_CCTL) ? cc_now :
      (ld_step == SP_ARM)  ? (arm_ch ? cc_arm : main_val(1'b0, 1'b0, 1'b1, cfg_ps)) :
      (ld_step == SP_CLR)  ? (arm_ch ? cc_now : main_val(1'b0, 1'b0, 1'b0, cfg_ps)) :
      main_val(1'b0, 1'b0, 1'b0, cfg_ps);
   wire            ld_write  = (ld_step != SP_RDFLAG);

   // interrupt pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_m_q <= 1'b0;
         irq_s_q <= 1'b0;
      end else begin
         irq_m_q <= timer_irq;
         irq_s_q <= irq_m_q;
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q <= TPC_PERIOD_RST;
         width_q  <= TPC_WIDTH_RST;
         config_q <= TPC_CONFIG_RST;
         err_q    <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         if (sw_wr && paddr == TPC_SW_PERIOD) period_q <= pwdata[15:0];
         if (sw_wr && paddr == TPC_SW_WIDTH)  width_q  <= pwdata[15:0];
         if (sw_wr && paddr == TPC_SW_CONFIG) config_q <= pwdata[10:0];
         if (cmd_any && cmd_bad)              err_q    <= 1'b1;
         else if (cmd_go)                     err_q    <= 1'b0;
         if (sw_setup)                        prdata_q <= rd_mux;
      end
   end

   // sequencer and master bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= ST_IDLE;
         mode_q      <= M_GO;
         step_q      <= SP_DONE;
         m_psel      <= 1'b0;
         m_penable   <= 1'b0;
         m_pwrite    <= 1'b0;
         m_paddr     <= 8'h00;
         m_pwdata    <= 32'h0;
         last_rd_q   <= 32'h0;
         last_odd_q  <= 3'b000;
         cur_width_q <= TPC_WIDTH_RST;
         irq_seen_q  <= 1'b0;
      end else begin
         if (ld_bus) begin
            m_psel    <= 1'b1;
            m_penable <= 1'b0;
            m_pwrite  <= ld_write;
            m_paddr   <= ld_addr;
            m_pwdata  <= {24'h0, ld_byte};
            step_q    <= ld_step;
            state_q   <= ST_SETUP;
            mode_q    <= ld_mode;
         end
         if (state_q == ST_IDLE && cmd_go) irq_seen_q <= 1'b0;
         if (state_q == ST_SETUP) begin
            m_penable <= 1'b1;
            state_q   <= ST_ACCESS;
         end
         if (state_q == ST_IRQ && irq_s_q) irq_seen_q <= 1'b1;
         if (xfer_done) begin
            if (!m_pwrite) last_rd_q <= m_prdata;
            if (step_q == SP_VALL) begin
               cur_width_q      <= width_q;
               last_odd_q[pair] <= val_ch[0];
            end
            if (!ld_bus) begin
               m_psel    <= 1'b0;
               m_penable <= 1'b0;
               step_q    <= nxt_step;
               state_q   <= (nxt_step == SP_WAIT) ? ST_IRQ : ST_IDLE;
            end
         end
      end
   end

   sequence s_done;
      m_psel && m_penable && m_pready;
   endsequence
   sequence s_cc_wr;
      m_psel && m_pwrite && m_paddr >= TPC_DEV_CH0 &&
      ((m_paddr - TPC_DEV_CH0) % TPC_DEV_CH_STR) == 8'h00;
   endsequence

   a_hold_request: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && m_penable && !m_pready |=> m_psel && m_penable && $stable(m_paddr) &&
      $stable(m_pwdata) && $stable(m_pwrite))
      else $error("request changed before pready");
   a_setup_access: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && !m_penable |=> m_psel && m_penable)
      else $error("setup not followed by access");
   a_no_toggle_cmp: assert property (@(posedge pclk) disable iff (!presetn)
      s_cc_wr |-> m_pwdata[TPC_CC_ACTH:TPC_CC_ACTL] != 2'b01)
      else $error("toggle on compare programmed");
   a_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
      s_cc_wr |-> m_pwdata[TPC_CC_BUF] != m_pwdata[TPC_CC_UNBUF])
      else $error("illegal mode select pair");
   a_rst_halted: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && m_pwrite && m_paddr == TPC_DEV_MAIN && m_pwdata[TPC_MAIN_RST] |->
      m_pwdata[TPC_MAIN_HALT] && mode_q == M_INIT)
      else $error("counter reset without halt");
   a_init_order: assert property (@(posedge pclk) disable iff (!presetn)
      (s_done ##0 (step_q == SP_PERL && mode_q == M_INIT)) |=>
      m_psel && m_paddr[7:0] == ch_base(cfg_ch) + TPC_DEV_VAL_H)
      else $error("width not loaded after period");
   a_go_unhalts: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && step_q == SP_GO |-> m_paddr == TPC_DEV_MAIN && !m_pwdata[TPC_MAIN_HALT])
      else $error("final step left counter halted");
   a_tov_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_cc_wr |-> m_pwdata[TPC_CC_TOV] == !config_q[TPC_CFG_ZERO])
      else $error("toggle_on_wrap wrong");
   a_buf_inactive: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && mode_q == M_BUF && step_q == SP_VALH |->
      m_paddr != ch_base({pair, last_odd_q[pair]}) + TPC_DEV_VAL_H)
      else $error("buffered write to active pair");
   a_unbuf_synced: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && mode_q == M_UNBUF && step_q == SP_VALH |-> irq_seen_q)
      else $error("unbuffered width written before interrupt");
   a_arm_target: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && step_q == SP_ARM |->
      (unb_short ? m_paddr == ch_base(cfg_ch) : m_paddr == TPC_DEV_MAIN))
      else $error("wrong interrupt armed");
   a_halt_wait: assert property (@(posedge pclk) disable iff (!presetn)
      m_psel && mode_q == M_HALT |-> m_pwdata[TPC_MAIN_HALT])
      else $error("halt command did not halt");
endmodule : tpc_host

// ==== design/tpc_pkg.sv ====
// shared constants and types for the timer pwm host controller
package tpc_pkg;
   // software-facing register byte offsets
   localparam logic [7:0] TPC_SW_CMD     = 8'h00;
   localparam logic [7:0] TPC_SW_PERIOD  = 8'h04;
   localparam logic [7:0] TPC_SW_WIDTH   = 8'h08;
   localparam logic [7:0] TPC_SW_CONFIG  = 8'h0c;
   localparam logic [7:0] TPC_SW_STATUS  = 8'h10;
   localparam logic [7:0] TPC_SW_LAST_RD = 8'h14;
   // command bits
   localparam int TPC_CMD_INIT   = 0;
   localparam int TPC_CMD_UPDATE = 1;
   localparam int TPC_CMD_HALT   = 2;
   localparam int TPC_CMD_RESUME = 3;
   // config fields
   localparam int TPC_CFG_CH_LSB = 0;
   localparam int TPC_CFG_BUF    = 3;
   localparam int TPC_CFG_SETCMP = 4;
   localparam int TPC_CFG_FULL   = 5;
   localparam int TPC_CFG_ZERO   = 6;
   localparam int TPC_CFG_PS_LSB = 8;
   // status fields
   localparam int TPC_ST_BUSY    = 0;
   localparam int TPC_ST_ERR     = 1;
   localparam int TPC_ST_ODD_LSB = 4;
   // reset values
   localparam logic [15:0] TPC_PERIOD_RST = 16'hffff;
   localparam logic [15:0] TPC_WIDTH_RST  = 16'h0000;
   localparam logic [10:0] TPC_CONFIG_RST = 11'h000;
   // timer unit register byte addresses
   localparam logic [7:0] TPC_DEV_MAIN   = 8'h00;
   localparam logic [7:0] TPC_DEV_PER_H  = 8'h0c;
   localparam logic [7:0] TPC_DEV_PER_L  = 8'h10;
   localparam logic [7:0] TPC_DEV_CH0    = 8'h14;
   localparam logic [7:0] TPC_DEV_CH_STR = 8'h0c;
   localparam logic [7:0] TPC_DEV_VAL_H  = 8'h04;
   localparam logic [7:0] TPC_DEV_VAL_L  = 8'h08;
   // timer_main_control bits
   localparam int TPC_MAIN_FLAG  = 7;
   localparam int TPC_MAIN_IRQEN = 6;
   localparam int TPC_MAIN_HALT  = 5;
   localparam int TPC_MAIN_RST   = 4;
   // channel_control bits
   localparam int TPC_CC_FLAG  = 7;
   localparam int TPC_CC_IRQEN = 6;
   localparam int TPC_CC_BUF   = 5;
   localparam int TPC_CC_UNBUF = 4;
   localparam int TPC_CC_ACTH  = 3;
   localparam int TPC_CC_ACTL  = 2;
   localparam int TPC_CC_TOV   = 1;
   localparam int TPC_CC_FULL  = 0;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_IRQ} tpc_state_t;
   typedef enum logic [2:0] {M_INIT, M_BUF, M_UNBUF, M_HALT, M_GO} tpc_mode_t;
   typedef enum logic [3:0] {
      SP_HALT, SP_RST, SP_PERH, SP_PERL, SP_VALH, SP_VALL, SP_CCTL, SP_GO,
      SP_ARM, SP_WAIT, SP_RDFLAG, SP_CLR, SP_DONE
   } tpc_step_t;
endpackage : tpc_pkg

// ==== verif/tb_top.sv ====
// self-checking bench for the timer pwm host controller
`timescale 1ns/1ps
module tb_top;
   import tpc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
   logic [7:0]  paddr, m_paddr, ra;
   logic [31:0] pwdata, prdata, m_prdata, m_pwdata, rd;
   logic        m_psel, m_penable, m_pwrite, m_pready, timer_irq, wrap_evt, odd, lg;
   logic [5:0]  ch_evt;
   logic [15:0] per, wid, old_w;
   logic [2:0]  ch;
   int          fail_count, n_tests, seed_v;

   tpc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite),
      .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready),
      .timer_irq(timer_irq));
   tpc_timer_model tim (.pclk(pclk), .presetn(presetn), .m_psel(m_psel),
      .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata),
      .m_prdata(m_prdata), .m_pready(m_pready), .wrap_evt(wrap_evt), .ch_evt(ch_evt),
      .timer_irq(timer_irq));

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // pops the next timer register write and compares the masked byte
   task automatic chk_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      logic [15:0] e;
      int          n;
      n = 0;
      while (tim.wlog.size() == 0 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      e = (tim.wlog.size() > 0) ? tim.wlog.pop_front() : 16'hxxxx;
      n_tests++;
      if (e[15:8] !== a || (e[7:0] & m) !== (d & m)) begin
         fail_count++;
         $display("[ERR] timer write expected %h:%h seen %h", a, d, e);
      end
   endtask : chk_wr

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_idle();
      rd = 32'h1;
      while (rd[TPC_ST_BUSY] !== 1'b0) begin
         apb(1'b0, TPC_SW_STATUS, 32'h0);
      end
   endtask : wait_idle

   function automatic logic [7:0] dev_ch(input logic [2:0] c);
      return TPC_DEV_CH0 + TPC_DEV_CH_STR * {5'h0, c};
   endfunction : dev_ch

   task automatic do_init(input logic [2:0] c, input logic b);
      logic [6:0] cf;
      cf = 7'($urandom);
      per = 16'($urandom);
      wid = 16'($urandom);
      apb(1'b1, TPC_SW_PERIOD, {16'h0, per});
      apb(1'b1, TPC_SW_WIDTH, {16'h0, wid});
      apb(1'b1, TPC_SW_CONFIG, {21'h0, cf[6:4], 1'b0, cf[2:0], b, c});
      apb(1'b1, TPC_SW_CMD, 32'h1);
      wait_idle();
      chk_wr(TPC_DEV_MAIN, 8'h20, 8'h30);
      chk_wr(TPC_DEV_MAIN, 8'h30, 8'h30);
      chk_wr(TPC_DEV_PER_H, per[15:8], 8'hff);
      chk_wr(TPC_DEV_PER_L, per[7:0], 8'hff);
      chk_wr(dev_ch(c) + TPC_DEV_VAL_H, wid[15:8], 8'hff);
      chk_wr(dev_ch(c) + TPC_DEV_VAL_L, wid[7:0], 8'hff);
      chk_wr(dev_ch(c), {2'b00, b, ~b, 1'b1, cf[0], ~cf[2], cf[1]},
             8'hff);
      chk_wr(TPC_DEV_MAIN, {5'h0, cf[6:4]}, 8'h37);
      old_w = wid;
   endtask : do_init

   initial begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      stop_test();
   end

   initial begin
      seed_v = $urandom(32'hbf69);
      {presetn, psel, penable, pwrite, wrap_evt} = 5'h0;
      {paddr, pwdata, ch_evt} = 46'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 1; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", (i == 1) ? 32'hffff : 32'h0, rd);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err_v});
      chk("unmapped data", 32'h0, rd);
      // buffered pairs alternate between odd and even value registers
      for (int p = 0; p < 3; p++) begin
         ch = 3'(2 * p);
         do_init(ch, 1'b1);
         odd = 1'b0;
         for (int k = 0; k < 2; k++) begin
            wid = 16'($urandom);
            apb(1'b1, TPC_SW_WIDTH, {16'h0, wid});
            apb(1'b1, TPC_SW_CMD, 32'h2);
            wait_idle();
            odd = ~odd;
            old_w = wid;
            chk_wr(dev_ch(ch + {2'b0, odd}) + TPC_DEV_VAL_H, wid[15:8], 8'hff);
            chk_wr(dev_ch(ch + {2'b0, odd}) + TPC_DEV_VAL_L, wid[7:0], 8'hff);
            chk("pair select", {31'h0, odd}, {31'h0, rd[TPC_ST_ODD_LSB + p]});
         end
      end
      // unbuffered: longer width waits for wrap, shorter for compare
      ch = 3'($urandom_range(5, 0));
      do_init(ch, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wid = k ? 16'(old_w >> 1) : {1'b1, old_w[14:0]};
         lg = !(wid < old_w);
         ra = lg ? TPC_DEV_MAIN : dev_ch(ch);
         apb(1'b1, TPC_SW_WIDTH, {16'h0, wid});
         apb(1'b1, TPC_SW_CMD, 32'h2);
         chk_wr(ra, 8'h40, 8'hc0);
         apb(1'b1, TPC_SW_CMD, 32'h4);
         apb(1'b0, TPC_SW_STATUS, 32'h0);
         chk("busy refusal", 32'h3, rd & 32'h3);
         wrap_evt <= lg;
         ch_evt <= lg ? 6'h0 : 6'(1 << ch);
         @(posedge pclk);
         wrap_evt <= 1'b0;
         ch_evt <= 6'h0;
         wait_idle();
         chk_wr(ra, 8'h00, 8'hc0);
         chk_wr(dev_ch(ch) + TPC_DEV_VAL_H, wid[15:8], 8'hff);
         chk_wr(dev_ch(ch) + TPC_DEV_VAL_L, wid[7:0], 8'hff);
         apb(1'b0, TPC_SW_LAST_RD, 32'h0);
         chk("last read flags", 32'hc0, rd & 32'hc0);
         old_w = wid;
      end
      apb(1'b1, TPC_SW_CMD, 32'h4);
      wait_idle();
      chk("error cleared", 32'h0, rd & 32'h2);
      chk_wr(TPC_DEV_MAIN, 8'h20, 8'h20);
      apb(1'b1, TPC_SW_CMD, 32'hc);
      wait_idle();
      chk_wr(TPC_DEV_MAIN, 8'h20, 8'h20);
      apb(1'b1, TPC_SW_CMD, 32'h8);
      wait_idle();
      chk_wr(TPC_DEV_MAIN, 8'h00, 8'h20);
      // an odd channel cannot lead a buffered pair
      apb(1'b1, TPC_SW_CONFIG, 32'h9);
      apb(1'b1, TPC_SW_CMD, 32'h1);
      wait_idle();
      chk("odd pair refusal", 32'h2, rd & 32'h3);
      repeat (20) @(posedge pclk);
      chk("spare writes", 32'h0, 32'(tim.wlog.size()));
      stop_test();
   end
endmodule : tb_top

// ==== verif/tpc_timer_model.sv ====
// behavioural timer unit answering the host controller's register bus
`timescale 1ns/1ps
module tpc_timer_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // register bus from the host
   input  wire logic        m_psel,
   input  wire logic        m_penable,
   input  wire logic        m_pwrite,
   input  wire logic [7:0]  m_paddr,
   input  wire logic [31:0] m_pwdata,
   output logic [31:0]      m_prdata,
   output logic             m_pready,
   // timer events and interrupt
   input  wire logic        wrap_evt,
   input  wire logic [5:0]  ch_evt,
   output logic             timer_irq
);
   import tpc_pkg::*;
   logic [7:0]  regs [256];
   logic [1:0]  wait_q;
   logic [31:0] last_q;
   logic [15:0] wlog [$];
   logic        irq_v;
   logic        done;

   function automatic logic is_ctl(input logic [7:0] a);
      return a >= TPC_DEV_CH0 && a <= 8'h50 && (a - TPC_DEV_CH0) % 8'h0c == 8'h00;
   endfunction : is_ctl

   assign done = m_psel && m_penable && m_pready;
   assign m_pready = m_psel && m_penable && wait_q == 2'd0;
   // released bus shows no stale value
   assign m_prdata = m_psel ? {24'h0, regs[m_paddr]} : ~last_q;
   always_comb begin
      irq_v = regs[TPC_DEV_MAIN][7] & regs[TPC_DEV_MAIN][6];
      for (int i = 0; i < 6; i++) begin
         irq_v = irq_v | (regs[8'(20 + 12 * i)][7] & regs[8'(20 + 12 * i)][6]);
      end
   end
   assign timer_irq = irq_v;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         foreach (regs[i]) regs[i] <= 8'h00;
         regs[TPC_DEV_MAIN] <= 8'h20;
         regs[TPC_DEV_PER_H] <= 8'hff;
         regs[TPC_DEV_PER_L] <= 8'hff;
         wait_q <= 2'd0;
         last_q <= 32'h0;
      end else begin
         if (m_psel && !m_penable) wait_q <= 2'($urandom_range(2, 0));
         else if (wait_q != 2'd0) wait_q <= wait_q - 2'd1;
         if (done) begin
            last_q <= m_prdata;
            if (m_pwrite) begin
               wlog.push_back({m_paddr, m_pwdata[7:0]});
               if (m_paddr == TPC_DEV_MAIN)
                  regs[0] <= {regs[0][7] & m_pwdata[7], m_pwdata[6:5], 1'b0, m_pwdata[3:0]};
               else if (is_ctl(m_paddr))
                  regs[m_paddr] <= {regs[m_paddr][7] & m_pwdata[7], m_pwdata[6:0]};
               else regs[m_paddr] <= m_pwdata[7:0];
            end
         end
         if (wrap_evt) regs[TPC_DEV_MAIN][7] <= 1'b1;
         for (int i = 0; i < 6; i++) if (ch_evt[i]) regs[8'(20 + 12 * i)][7] <= 1'b1;
      end
   end
endmodule : tpc_timer_model
